/* design/edm_port.sv */
`timescale 1ns/10ps
`default_nettype none
module edm_port
	import edm_pkg::*;
(
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic SYS_RST_I,
	// Core request side
	input wire logic REQ_VALID_I,
	input wire logic REQ_WRITE_I,
	input wire logic REQ_SPACE_Y_I,
	input wire logic [edm_pkg::ADDR_W-1:0] REQ_ADDR_I,
	input wire logic [edm_pkg::DATA_W-1:0] REQ_WDATA_I,
	output logic REQ_READY_O,
	output logic RSP_VALID_O,
	output logic [edm_pkg::DATA_W-1:0] RSP_RDATA_O,
	// External memory pins
	output logic MEM_SPACE_Y_O,
	output logic MEM_SPACE_Y_OE_O,
	output logic [edm_pkg::ADDR_W-1:0] EXT_MEM_ADDR_O,
	output logic EXT_MEM_ADDR_OE_O,
	input wire logic [edm_pkg::DATA_W-1:0] EXT_MEM_DATA_I,
	output logic [edm_pkg::DATA_W-1:0] EXT_MEM_DATA_O,
	output logic EXT_MEM_DATA_OE_O,
	output logic MEM_READ_STROBE_N_O,
	output logic MEM_WRITE_STROBE_N_O,
	output logic MEM_STROBE_OE_O,
	input wire logic MEM_WAIT_I,
	// Bus borrow handshake
	input wire logic BUS_BORROW_REQUEST_N_I,
	output logic BUS_BORROW_GRANT_N_O,
	output logic BUS_OCCUPIED_N_O
);
	import edm_pkg::*;

	typedef struct packed {
		edm_state_e state;
		logic wr;
		logic sel_y;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic rsp;
		logic [DATA_W-1:0] rdata;
	} edm_st_s;

	edm_st_s st_reg;
	edm_st_s st_next;
	logic grant;
	logic busy;

	assign grant = (st_reg.state == EDM_HOLD);
	assign busy = (st_reg.state == EDM_ACC);
	// New accesses only while bus is ours and nobody asks for it
	assign REQ_READY_O = (st_reg.state == EDM_IDLE) && BUS_BORROW_REQUEST_N_I;

	always_comb begin
		st_next = st_reg;
		st_next.rsp = 1'b0;
		case (st_reg.state)
			EDM_IDLE: begin
				if (!BUS_BORROW_REQUEST_N_I) begin
					st_next.state = EDM_HOLD;
				end else if (REQ_VALID_I) begin
					st_next.state = EDM_ACC;
					st_next.wr = REQ_WRITE_I;
					st_next.sel_y = REQ_SPACE_Y_I;
					st_next.addr = REQ_ADDR_I;
					st_next.wdata = REQ_WDATA_I;
				end
			end
			EDM_ACC: begin
				if (st_reg.wr || !MEM_WAIT_I) begin
					st_next.state = EDM_IDLE;
					st_next.rsp = 1'b1;
					if (!st_reg.wr) begin
						st_next.rdata = EXT_MEM_DATA_I;
					end
				end
			end
			EDM_HOLD: begin
				if (BUS_BORROW_REQUEST_N_I) begin
					st_next.state = EDM_IDLE;
				end
			end
			default: begin
				st_next.state = EDM_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			st_reg <= '{state: EDM_IDLE, wr: 1'b0, sel_y: 1'b0, addr: ADDR_RST,
				wdata: DATA_RST, rsp: 1'b0, rdata: DATA_RST};
		end else begin
			st_reg <= st_next;
		end
	end

	assign MEM_SPACE_Y_O = st_reg.sel_y;
	assign EXT_MEM_ADDR_O = st_reg.addr;
	assign EXT_MEM_DATA_O = st_reg.wdata;
	assign MEM_SPACE_Y_OE_O = !grant;
	assign EXT_MEM_ADDR_OE_O = !grant;
	assign MEM_STROBE_OE_O = !grant;
	assign EXT_MEM_DATA_OE_O = busy && st_reg.wr;
	assign MEM_READ_STROBE_N_O = !(busy && !st_reg.wr);
	assign MEM_WRITE_STROBE_N_O = !(busy && st_reg.wr);
	assign BUS_OCCUPIED_N_O = !busy;
	assign BUS_BORROW_GRANT_N_O = !grant;
	assign RSP_VALID_O = st_reg.rsp;
	assign RSP_RDATA_O = st_reg.rdata;


	chk_strobe_excl: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		!(!MEM_READ_STROBE_N_O && !MEM_WRITE_STROBE_N_O))
		else $error("both strobes low");

	chk_float_hold: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		!BUS_BORROW_GRANT_N_O |-> !EXT_MEM_ADDR_OE_O && !EXT_MEM_DATA_OE_O
		&& !MEM_STROBE_OE_O && !MEM_SPACE_Y_OE_O)
		else $error("pins driven while granted");

	chk_oe_normal: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		BUS_BORROW_GRANT_N_O |-> MEM_SPACE_Y_OE_O && EXT_MEM_ADDR_OE_O && MEM_STROBE_OE_O)
		else $error("pins floating while not granted");

	chk_grant_idle: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		$fell(BUS_BORROW_GRANT_N_O) |-> $past(BUS_OCCUPIED_N_O) && BUS_OCCUPIED_N_O)
		else $error("grant during access");

	chk_grant_release: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		!BUS_BORROW_GRANT_N_O && BUS_BORROW_REQUEST_N_I |=> BUS_BORROW_GRANT_N_O)
		else $error("grant not released");

	chk_grant_given: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		!BUS_BORROW_REQUEST_N_I && BUS_OCCUPIED_N_O && BUS_BORROW_GRANT_N_O
		|=> !BUS_BORROW_GRANT_N_O)
		else $error("grant not given");

	chk_grant_keep: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		!BUS_BORROW_GRANT_N_O && !BUS_BORROW_REQUEST_N_I |=> !BUS_BORROW_GRANT_N_O)
		else $error("grant dropped while requested");

	chk_borrow_first: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		!BUS_BORROW_REQUEST_N_I && BUS_OCCUPIED_N_O |=> BUS_OCCUPIED_N_O)
		else $error("access started against borrow request");

	chk_ready_refuse: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		!BUS_OCCUPIED_N_O || !BUS_BORROW_GRANT_N_O || !BUS_BORROW_REQUEST_N_I
		|-> !REQ_READY_O)
		else $error("ready while bus not free");

	chk_wait_stretch: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		!MEM_READ_STROBE_N_O && MEM_WAIT_I |=> !MEM_READ_STROBE_N_O)
		else $error("read ended under wait");

	chk_read_end: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		!MEM_READ_STROBE_N_O && !MEM_WAIT_I |=> MEM_READ_STROBE_N_O && RSP_VALID_O)
		else $error("read not ended");

	chk_read_sample: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		!MEM_READ_STROBE_N_O && !MEM_WAIT_I |=> RSP_RDATA_O == $past(EXT_MEM_DATA_I))
		else $error("read data not captured");

	chk_data_drive: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		EXT_MEM_DATA_OE_O == !MEM_WRITE_STROBE_N_O)
		else $error("data drive outside write");

	chk_write_single: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		!MEM_WRITE_STROBE_N_O |=> MEM_WRITE_STROBE_N_O && RSP_VALID_O)
		else $error("write not one cycle");

	chk_write_data: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		REQ_VALID_I && REQ_READY_O && REQ_WRITE_I |=> EXT_MEM_DATA_O == $past(REQ_WDATA_I))
		else $error("write data not latched");

	chk_addr_latch: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		REQ_VALID_I && REQ_READY_O |=> EXT_MEM_ADDR_O == $past(REQ_ADDR_I))
		else $error("address not latched");

	chk_addr_hold: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		!(REQ_VALID_I && REQ_READY_O) |=> $stable(EXT_MEM_ADDR_O))
		else $error("address moved between accesses");

	chk_space_latch: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		REQ_VALID_I && REQ_READY_O |=> MEM_SPACE_Y_O == $past(REQ_SPACE_Y_I))
		else $error("space select not latched");

	chk_strobe_kind: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		REQ_VALID_I && REQ_READY_O |=> MEM_WRITE_STROBE_N_O == !$past(REQ_WRITE_I)
		&& MEM_READ_STROBE_N_O == $past(REQ_WRITE_I))
		else $error("wrong strobe for access");

	chk_occ_strobe: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
		!BUS_OCCUPIED_N_O == (!MEM_READ_STROBE_N_O || !MEM_WRITE_STROBE_N_O))
		else $error("occupied strobe mismatch");

	chk_addr_reset: assert property (@(posedge REF_CLK_I)
		!SYS_RST_I && $past(SYS_RST_I) |-> EXT_MEM_ADDR_O == ADDR_RST)
		else $error("address not zero after reset");
endmodule // edm_port
`default_nettype wire

/* design/edm_pkg.sv */
// Contract
// - Select output low picks X data space, high picks Y, on each access.
// - Drive 14-bit address on each access; hold last value between accesses.
// - Address outputs are zero after reset until the first access.
// - 16-bit data bus is driven on writes and sampled on reads.
// - Wait input stretches a read for as long as it is asserted.
// - Bus occupied strobe is low while the port uses the bus.
// - Borrow grant goes low when the bus is handed to the outside master.
// - While granted, select, address, data and both strobes float.
`default_nettype none
package edm_pkg;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

	typedef enum logic [1:0] {
		EDM_IDLE = 2'b00,
		EDM_ACC = 2'b01,
		EDM_HOLD = 2'b10
	} edm_state_e;
endpackage
`default_nettype wire

/* verif/edm_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module edm_mem_model (
	input wire logic clk_i,
	input wire logic space_y_i,
	input wire logic [13:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic oe_i,
	input wire logic [1:0] wait_len_i,
	output logic [15:0] rdata_o,
	output logic wait_o
);
	logic [15:0] mem [32];
	logic [1:0] cnt_reg = 2'h0;
	logic [15:0] last_reg = 16'h0;
	assign wait_o = !rd_n_i && oe_i && cnt_reg < wait_len_i;
	assign rdata_o = (!rd_n_i && oe_i) ? mem[{space_y_i, addr_i[3:0]}] : ~last_reg;
	always @(posedge clk_i) begin
		last_reg <= rdata_o;
		cnt_reg <= (!rd_n_i && oe_i) ? cnt_reg + 2'h1 : 2'h0;
		if (!wr_n_i && oe_i)
			mem[{space_y_i, addr_i[3:0]}] <= wdata_i;
	end
endmodule // edm_mem_model
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import edm_pkg::*;
	logic clk = 0, rst = 1, vld = 0, wr = 0, sy = 0, rq_n = 1;
	logic [13:0] ad = 0, ma;
	logic [15:0] wd = 0, rdat, dq, md, bus;
	logic [15:0] exp_m [32];
	logic [1:0] wl = 0;
	logic rdy, rsp, sel, sel_oe, ma_oe, d_oe, rd_n, wr_n, s_oe, mwait, gnt_n, occ_n;
	int n_fail = 0, n_tests = 0, seed = 32'hfaa03461;
	assign bus = d_oe ? dq : md;
	always #12.5 clk = ~clk;
	edm_port i_dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .REQ_VALID_I(vld), .REQ_WRITE_I(wr),
		.REQ_SPACE_Y_I(sy), .REQ_ADDR_I(ad), .REQ_WDATA_I(wd), .REQ_READY_O(rdy),
		.RSP_VALID_O(rsp), .RSP_RDATA_O(rdat), .MEM_SPACE_Y_O(sel), .MEM_SPACE_Y_OE_O(sel_oe),
		.EXT_MEM_ADDR_O(ma), .EXT_MEM_ADDR_OE_O(ma_oe), .EXT_MEM_DATA_I(bus),
		.EXT_MEM_DATA_O(dq), .EXT_MEM_DATA_OE_O(d_oe), .MEM_READ_STROBE_N_O(rd_n),
		.MEM_WRITE_STROBE_N_O(wr_n), .MEM_STROBE_OE_O(s_oe), .MEM_WAIT_I(mwait),
		.BUS_BORROW_REQUEST_N_I(rq_n), .BUS_BORROW_GRANT_N_O(gnt_n), .BUS_OCCUPIED_N_O(occ_n));
	edm_mem_model i_mem (.clk_i(clk), .space_y_i(sel), .addr_i(ma), .wdata_i(bus),
		.rd_n_i(rd_n), .wr_n_i(wr_n), .oe_i(s_oe), .wait_len_i(wl), .rdata_o(md),
		.wait_o(mwait));
	task automatic test_done;
		$display("checks %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic rst_chk;
		@(posedge clk);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		@(negedge clk);
		chk("reset", 32'h78000, {rd_n, wr_n, gnt_n, occ_n, sel, ma});
		chk("reset_oe", 32'hd, {sel_oe, ma_oe, d_oe, s_oe});
	endtask
	task automatic acc(input logic w, y, b, input logic [13:0] a, input logic [15:0] d);
		int k;
		k = 0;
		@(posedge clk);
		vld <= 1;
		wr <= w;
		sy <= y;
		ad <= a;
		wd <= d;
		do begin @(posedge clk); k++; end while (rdy !== 1'b1 && k < 20);
		vld <= 0;
		if (b)
			rq_n <= 0;
		if (k > 19) begin
			n_fail++;
			test_done();
		end
		k = 0;
		do begin
			@(negedge clk);
			k++;
			if (k == 1) begin
				chk("pins", {w, !w, 2'b01, y, a}, {rd_n, wr_n, occ_n, gnt_n, sel, ma});
				chk("doe", w, d_oe);
				if (w)
					chk("wdata", d, dq);
			end
		end while (rsp !== 1'b1 && k < 20);
		chk("lat", w ? 2 : 2 + wl, k);
		if (!w)
			chk("rdata", exp_m[{y, a[3:0]}], rdat);
		else
			exp_m[{y, a[3:0]}] = d;
		if (k > 19) begin
			n_fail++;
			test_done();
		end
	endtask
	task automatic hold;
		int k;
		k = 0;
		@(posedge clk);
		// Outside master asks for the bus
		rq_n <= 0;
		do begin @(negedge clk); k++; end while (gnt_n !== 1'b0 && k < 20);
		chk("float", 32'h10, {occ_n, sel_oe, ma_oe, d_oe, s_oe});
		@(posedge clk);
		rq_n <= 1;
		@(negedge clk);
		chk("stand", 32'h0, gnt_n);
		@(negedge clk);
		chk("back", 32'h3d, {gnt_n, occ_n, sel_oe, ma_oe, d_oe, s_oe});
		if (k > 19) begin
			n_fail++;
			test_done();
		end
	endtask
	initial begin
		rst_chk();
		acc(1, 1, 0, 14'h3fff, 16'hffff);
		for (int i = 0; i < 32; i++)
			acc(1, i[4], 0, {10'($random(seed)), i[3:0]}, 16'($random(seed)));
		$display("writes done");
		rst_chk();
		for (int i = 0; i < 48; i++) begin
			wl = 2'($random(seed));
			acc(0, i[4], i % 5 == 0, {10'($random(seed)), 4'($random(seed))}, 16'h0);
			if (i % 5 == 0)
				hold();
		end
		$display("reads done");
		test_done();
	end
endmodule // testbench
`default_nettype wire
